/* File: design/fab_fifo.sv */
// 1024 x 18 fifo with programmable almost-boundary flag and half-full flag
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - store 1024 words of 18 bits, in order
// - read word equals written word, no inversion
// - write and read sides run independently
// - flag high at count <= X+1 or >= 1025-X
// - flag low between X+2 and 1024-X
// - default offset is 256 words
// - offset is set anew on every reset
// - reset rises with strobe low: user offset used
// - strobe fall latches low nine data bits
// - strobe high through reset selects default
// - strobe kept low retains previous captured offset
// - half-full high at 513 or more words
module fab_fifo (
	// clock and power-on reset
	input wire logic CLK,
	input wire logic ARST_N,
	// documented reset pulse and offset strobe, asynchronous pins
	input wire logic FIFO_RESET_N,
	input wire logic OFFSET_DEFINE_STROBE_N,
	// write side
	input wire logic WRITE_EN,
	input wire logic [fab_pkg::DATA_W-1:0] WRITE_BUS,
	output logic WRITE_READY,
	// read side
	input wire logic READ_EN,
	output logic NOT_EMPTY,
	output logic READ_VALID,
	output logic [fab_pkg::DATA_W-1:0] READ_BUS,
	// flags
	output logic ALMOST_BOUNDARY_FLAG,
	output logic HALF_FULL_FLAG
);
	logic strobe_s1_r, strobe_s2_r, strobe_s3_r;
	logic rst_s1_r, rst_s2_r;
	logic strobe_fall, rst_release, hold;
	logic [fab_pkg::OFS_W-1:0] captured_r, ofs_r, ofs_nxt, capture_src;
	logic [fab_pkg::DATA_W-1:0] mem_r [fab_pkg::DEPTH];
	logic [fab_pkg::PTR_W-1:0] wr_ptr_r, rd_ptr_r;
	logic [fab_pkg::CNT_W-1:0] count_r, count_nxt;
	logic do_wr, do_rd;
	fab_pkg::fab_state_t state_r;

	// boundary test, shared by the flag register and the flag_high_a check
	function automatic logic near_edge(input logic [fab_pkg::CNT_W-1:0] cnt,
			input logic [fab_pkg::OFS_W-1:0] ofs);
		logic [fab_pkg::CNT_W-1:0] x;
		x = {2'h0, ofs};
		near_edge = (cnt <= x + 11'h001) || (cnt >= fab_pkg::HIGH_EDGE - x);
	endfunction

	// two-flop synchronisers; the third flop only serves edge detection
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			strobe_s1_r <= 1'b1;
			strobe_s2_r <= 1'b1;
			strobe_s3_r <= 1'b1;
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			strobe_s1_r <= OFFSET_DEFINE_STROBE_N;
			strobe_s2_r <= strobe_s1_r;
			strobe_s3_r <= strobe_s2_r;
			rst_s1_r <= FIFO_RESET_N;
			rst_s2_r <= rst_s1_r;
		end
	end

	assign strobe_fall = strobe_s3_r & ~strobe_s2_r;
	assign rst_release = (state_r == fab_pkg::FAB_HOLD) & rst_s2_r; // first synced-high cycle
	assign hold = ~rst_s2_r;
	// a fall in the release cycle still counts, so take the bus directly
	assign capture_src = strobe_fall ? WRITE_BUS[fab_pkg::OFS_W-1:0] : captured_r;

	// offset latch on the strobe's falling edge; bus must be stable around it
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			captured_r <= fab_pkg::DEFAULT_OFS;
		end else if (strobe_fall) begin
			captured_r <= WRITE_BUS[fab_pkg::OFS_W-1:0];
		end
	end

	// active offset chosen at each reset release
	always_comb begin
		ofs_nxt = ofs_r;
		if (rst_release) begin
			if (strobe_s2_r) begin
				ofs_nxt = fab_pkg::DEFAULT_OFS;
			end else begin
				ofs_nxt = capture_src;
			end
		end
	end

	// reset sequencing state and active offset
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r <= fab_pkg::FAB_HOLD;
			ofs_r <= fab_pkg::DEFAULT_OFS;
		end else begin
			ofs_r <= ofs_nxt;
			case (state_r)
				fab_pkg::FAB_RUN: begin
					if (hold) begin
						state_r <= fab_pkg::FAB_HOLD;
					end
				end
				fab_pkg::FAB_HOLD: begin
					if (rst_release) begin
						state_r <= fab_pkg::FAB_RUN;
					end
				end
				default: begin
					state_r <= fab_pkg::FAB_HOLD;
				end
			endcase
		end
	end

	// transfers are refused while the reset pulse is held
	assign do_wr = WRITE_EN & (count_r != fab_pkg::DEPTH_CNT) & ~hold;
	assign do_rd = READ_EN & (count_r != fab_pkg::CNT_RST) & ~hold;
	assign WRITE_READY = ~hold & (count_r != fab_pkg::DEPTH_CNT);
	assign NOT_EMPTY = ~hold & (count_r != fab_pkg::CNT_RST);

	// occupancy; a word written into an empty fifo is readable next cycle
	always_comb begin
		count_nxt = count_r + {10'h000, do_wr} - {10'h000, do_rd};
		if (hold) begin
			count_nxt = fab_pkg::CNT_RST;
		end
	end

	// storage, written in arrival order; no reset needed on the array
	always_ff @(posedge CLK) begin
		if (do_wr) begin
			mem_r[wr_ptr_r] <= WRITE_BUS;
		end
	end

	// write position
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_ptr_r <= fab_pkg::PTR_RST;
		end else if (hold) begin
			wr_ptr_r <= fab_pkg::PTR_RST;
		end else if (do_wr) begin
			wr_ptr_r <= wr_ptr_r + 10'h001;
		end
	end

	// read position and registered read data
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rd_ptr_r <= fab_pkg::PTR_RST;
			READ_BUS <= fab_pkg::DATA_RST;
			READ_VALID <= 1'b0;
		end else begin
			READ_VALID <= do_rd;
			if (hold) begin
				rd_ptr_r <= fab_pkg::PTR_RST;
			end else if (do_rd) begin
				rd_ptr_r <= rd_ptr_r + 10'h001;
				READ_BUS <= mem_r[rd_ptr_r];
			end
		end
	end

	// count and flags registered together so they always agree
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			count_r <= fab_pkg::CNT_RST;
			ALMOST_BOUNDARY_FLAG <= 1'b1;
			HALF_FULL_FLAG <= 1'b0;
		end else begin
			count_r <= count_nxt;
			ALMOST_BOUNDARY_FLAG <= near_edge(count_nxt, ofs_nxt);
			HALF_FULL_FLAG <= (count_nxt >= fab_pkg::HALF_LEVEL);
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	depth_bound_a: assert property (count_r <= fab_pkg::DEPTH_CNT)
		else $error("occupancy above depth");
	ptr_order_a: assert property (
		{1'b0, wr_ptr_r - rd_ptr_r} == count_r[fab_pkg::PTR_W:0]
		|| count_r == fab_pkg::DEPTH_CNT)
		else $error("pointers disagree with occupancy");
	data_pass_a: assert property (do_rd |=> READ_VALID && READ_BUS == $past(mem_r[rd_ptr_r]))
		else $error("read data not the stored word");
	read_alone_a: assert property (do_rd && !do_wr |=> count_r == $past(count_r) - 11'h001)
		else $error("read did not lower occupancy");
	flag_high_a: assert property (near_edge(count_r, ofs_r) |-> ALMOST_BOUNDARY_FLAG)
		else $error("boundary flag low near an edge");
	flag_low_a: assert property (count_r >= {2'h0, ofs_r} + 11'h002
		&& count_r <= fab_pkg::DEPTH_CNT - {2'h0, ofs_r} |-> !ALMOST_BOUNDARY_FLAG)
		else $error("boundary flag high in mid range");
	default_ofs_a: assert property (rst_release && strobe_s2_r |=> ofs_r == fab_pkg::DEFAULT_OFS)
		else $error("default offset not applied");
	user_ofs_a: assert property (rst_release && !strobe_s2_r && !strobe_fall
		|=> ofs_r == $past(captured_r))
		else $error("captured offset not applied");
	ofs_stable_a: assert property (!rst_release |=> $stable(ofs_r))
		else $error("offset changed outside reset release");
	capture_a: assert property (strobe_fall |=> captured_r == $past(WRITE_BUS[8:0]))
		else $error("offset not latched on strobe fall");
	half_full_a: assert property (HALF_FULL_FLAG == (count_r >= fab_pkg::HALF_LEVEL))
		else $error("half-full flag wrong");
	reset_empty_a: assert property (hold |=> count_r == fab_pkg::CNT_RST && !NOT_EMPTY)
		else $error("reset did not empty fifo");

	fill_full_c: cover property (count_r == fab_pkg::DEPTH_CNT);
	user_ofs_c: cover property (rst_release && !strobe_s2_r ##1 ofs_r != fab_pkg::DEFAULT_OFS);
	both_sides_c: cover property (do_rd && do_wr);
	flag_drop_c: cover property (ALMOST_BOUNDARY_FLAG ##1 !ALMOST_BOUNDARY_FLAG);
endmodule // fab_fifo

`default_nettype wire

/* File: inc/fab_pkg.sv */
// constants shared by the almost-boundary fifo
`default_nettype none
package fab_pkg;
	localparam int DATA_W = 18;
	localparam int DEPTH = 1024;
	localparam int PTR_W = 10;
	localparam int CNT_W = 11;
	localparam int OFS_W = 9;
	localparam logic [CNT_W-1:0] DEPTH_CNT = 11'h400;
	localparam logic [CNT_W-1:0] HIGH_EDGE = 11'h401;
	localparam logic [CNT_W-1:0] HALF_LEVEL = 11'h201;
	localparam logic [OFS_W-1:0] DEFAULT_OFS = 9'h100;
	localparam logic [CNT_W-1:0] CNT_RST = 11'h000;
	localparam logic [PTR_W-1:0] PTR_RST = 10'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
	// one-hot states of the fifo reset sequencing
	typedef enum logic [1:0] {
		FAB_RUN = 2'b01,
		FAB_HOLD = 2'b10
	} fab_state_t;
endpackage
`default_nettype wire

/* File: tb/fab_fifo_tb.sv */
// self-checking bench for the almost-boundary fifo
`timescale 1ns/1ps
`default_nettype none
module fab_fifo_tb;
	logic CLK = 0, ARST_N = 0, FIFO_RESET_N = 1, OFFSET_DEFINE_STROBE_N = 1;
	logic WRITE_EN, READ_EN, WRITE_READY, NOT_EMPTY, READ_VALID;
	logic ALMOST_BOUNDARY_FLAG, HALF_FULL_FLAG;
	logic [fab_pkg::DATA_W-1:0] wdata, READ_BUS;
	logic go_wr = 0, go_rd = 0, clr = 1, prog = 0, chk = 0;
	logic [8:0] pv = 9'h000;
	int count, x = 256, rseq = 0, cyc = 0, n_mismatch = 0, n_tests = 0;
	always #2 CLK = ~CLK;
	fab_fifo fab_fifo_i (.CLK(CLK), .ARST_N(ARST_N), .FIFO_RESET_N(FIFO_RESET_N),
		.OFFSET_DEFINE_STROBE_N(OFFSET_DEFINE_STROBE_N), .WRITE_EN(WRITE_EN),
		.WRITE_BUS(prog ? {9'h000, pv} : wdata), .WRITE_READY(WRITE_READY),
		.READ_EN(READ_EN), .NOT_EMPTY(NOT_EMPTY), .READ_VALID(READ_VALID),
		.READ_BUS(READ_BUS), .ALMOST_BOUNDARY_FLAG(ALMOST_BOUNDARY_FLAG),
		.HALF_FULL_FLAG(HALF_FULL_FLAG));
	fab_peer fab_peer_i (.CLK(CLK), .WRITE_READY(WRITE_READY), .NOT_EMPTY(NOT_EMPTY),
		.go_wr(go_wr), .go_rd(go_rd), .clr(clr), .WRITE_EN(WRITE_EN), .wdata(wdata),
		.READ_EN(READ_EN), .count(count));
	task automatic check(input string nm, input logic [17:0] e, input logic [17:0] s);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// flags are judged every cycle outside reset pulses against the model count, so fill and drain sweep all levels
	always @(negedge CLK) begin
		if (READ_VALID === 1'b1) begin
			check("read data", {rseq[9:0] ^ 10'h2b5, rseq[7:0]}, READ_BUS);
			rseq++;
		end
		if (chk) begin
			check("almost flag", 18'(count <= x + 1 || count >= 1025 - x), 18'(ALMOST_BOUNDARY_FLAG));
			check("half flag", 18'(count >= 513), 18'(HALF_FULL_FLAG));
		end
	end
	// hang guard, ample for five full fill and drain passes
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	// reset pulse; sel 1 programs v first, sel 2 raises the strobe, sel 0 keeps it low
	task automatic freset(input int sel, input logic [8:0] v);
		chk = 0;
		if (sel == 1) begin
			prog = 1;
			pv = v;
			OFFSET_DEFINE_STROBE_N = 1;
			repeat (3) @(negedge CLK);
			OFFSET_DEFINE_STROBE_N = 0;
			repeat (4) @(negedge CLK);
		end
		if (sel == 2)
			OFFSET_DEFINE_STROBE_N = 1;
		FIFO_RESET_N = 0;
		clr = 1;
		repeat (5) @(negedge CLK);
		FIFO_RESET_N = 1;
		repeat (5) @(negedge CLK);
		clr = 0;
		rseq = 0;
		prog = 0;
		chk = 1;
	endtask
	// fill past full so extra writes are refused, then drain past empty
	task automatic fill_drain();
		int s;
		int i;
		s = rseq;
		// non-blocking so the peer samples the command a full cycle later, never racing it
		go_wr <= 1'b1;
		for (i = 0; i < 1100 && WRITE_READY !== 1'b0; i++) @(negedge CLK);
		repeat (4) @(negedge CLK);
		check("write ready", 18'h0, 18'(WRITE_READY));
		go_wr <= 1'b0;
		go_rd <= 1'b1;
		for (i = 0; i < 1100 && NOT_EMPTY !== 1'b0; i++) @(negedge CLK);
		repeat (4) @(negedge CLK);
		go_rd <= 1'b0;
		check("not empty", 18'h0, 18'(NOT_EMPTY));
		check("words read", 18'h00400, 18'(rseq - s));
	endtask
	initial begin
		repeat (12) @(negedge CLK);
		ARST_N = 1;
		repeat (5) @(negedge CLK);
		clr = 0;
		chk = 1;
		fill_drain();
		x = 0;
		freset(1, 9'h000);
		fill_drain();
		x = 511;
		freset(1, 9'h1ff);
		fill_drain();
		// overlap reads with writes, then leave words behind for the reset to clear
		go_wr <= 1'b1;
		repeat (10) @(negedge CLK);
		go_rd <= 1'b1;
		repeat (20) @(negedge CLK);
		check("words left", 18'h1, 18'(NOT_EMPTY));
		go_wr <= 1'b0;
		go_rd <= 1'b0;
		freset(0, 9'h000);
		check("not empty", 18'h0, 18'(NOT_EMPTY));
		fill_drain();
		x = 256;
		freset(2, 9'h000);
		fill_drain();
		final_report();
	end
endmodule // fab_fifo_tb
`default_nettype wire

/* File: tb/fab_peer.sv */
// writer and reader logic facing the fifo
`timescale 1ns/1ps
`default_nettype none
module fab_peer (
	// clock and fifo status
	input wire logic CLK,
	input wire logic WRITE_READY,
	input wire logic NOT_EMPTY,
	// bench commands
	input wire logic go_wr,
	input wire logic go_rd,
	input wire logic clr,
	// requests and stored word count
	output logic WRITE_EN = 0,
	output logic [fab_pkg::DATA_W-1:0] wdata = 0,
	output logic READ_EN = 0,
	output int count = 0
);
	int wseq = 0;
	// requests move off the sampling edge; an idle bus inverts every cycle, alternating between the last word and its inverse
	always @(negedge CLK) begin
		WRITE_EN <= go_wr;
		READ_EN <= go_rd;
		wdata <= go_wr ? {wseq[9:0] ^ 10'h2b5, wseq[7:0]} : ~wdata;
	end
	// refused writes are retried, so the sequence only advances on acceptance
	always @(posedge CLK) begin
		if (clr) begin
			count <= 0;
			wseq <= 0;
		end else begin
			count <= count + int'(WRITE_EN && WRITE_READY) - int'(READ_EN && NOT_EMPTY);
			wseq <= wseq + int'(WRITE_EN && WRITE_READY);
		end
	end
endmodule // fab_peer
`default_nettype wire
